// *** rtl/msf_regs.svh ***
// Register offsets, field positions, reset values and depths of the sample queue status block
`ifndef MSF_REGS_SVH
`define MSF_REGS_SVH

// Register offsets; status and mode offsets shared by both units, the others per unit
`define MSF_OFS_INT_STATUS    8'h0a
`define MSF_OFS_QUEUE_STATUS  8'h0e
`define MSF_OFS_GYR_IRQ_EN    8'h15
`define MSF_OFS_ACC_IRQ_EN    8'h17
`define MSF_OFS_GYR_PIN_MAP   8'h18
`define MSF_OFS_ACC_PIN_MAP   8'h1a
`define MSF_OFS_GYR_WM_EN     8'h1e
`define MSF_OFS_ACC_WM_LEVEL  8'h30
`define MSF_OFS_GYR_SYNC_CFG  8'h34
`define MSF_OFS_GYR_WM_LEVEL  8'h3d
`define MSF_OFS_QUEUE_MODE    8'h3e

// Field positions
`define MSF_BIT_SYNC_EN       5
`define MSF_BIT_SYNC_SEL      4
`define MSF_BIT_GYR_QUEUE_EN  6
`define MSF_BIT_ACC_WM_EN     6
`define MSF_BIT_ACC_FULL_EN   5
`define MSF_BIT_ACC_WM_P1     1
`define MSF_BIT_ACC_WM_P2     6
`define MSF_BIT_ACC_FULL_P1   2
`define MSF_BIT_ACC_FULL_P2   5
`define MSF_BIT_GYR_WM_IRQ    7
`define MSF_BIT_GYR_Q_P1      2
`define MSF_BIT_GYR_Q_P2      5
`define MSF_BIT_ST_ACC_WM     6
`define MSF_BIT_ST_ACC_FULL   5
`define MSF_BIT_ST_GYR_Q      4

// Operating mode codes, bits 7:6 of the mode register
`define MSF_MODE_BYPASS       2'h0
`define MSF_MODE_FIFO         2'h1
`define MSF_MODE_STREAM       2'h2

// Depths in frames
`define MSF_ACC_DEPTH_FIFO    7'h20
`define MSF_ACC_DEPTH_STREAM  7'h1f
`define MSF_GYR_DEPTH_FIFO    7'h64
`define MSF_GYR_DEPTH_STREAM  7'h63
`define MSF_DEPTH_BYPASS      7'h01

// Reset values
`define MSF_REG_RESET         8'h00
`define MSF_CNT_RESET         7'h00

`endif

// *** rtl/msf_pkg.sv ***
// Types of the sample queue status block
package msf_pkg;

   // Queue status as read back: overrun flag over fill count
   typedef struct packed {
      logic       ovr;
      logic [6:0] cnt;
   } msf_qstat_t;

   // Tagging controls carried into the sample domain
   typedef struct packed {
      logic sel;
      logic en;
   } msf_smp_cfg_t;

endpackage : msf_pkg

// *** rtl/msf_status_sync.sv ***
// Fill level, overrun, watermark/full events and gyro sync tagging of the sample queues
`include "msf_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module msf_status_sync
   import msf_pkg::*;
(
   // Clocks and reset
   input  wire logic        MCLK_I,
   input  wire logic        SMP_CLK_I,
   input  wire logic        RESET_N_I,
   // Register port, unit 0 accel, unit 1 gyro
   input  wire logic        REG_UNIT_I,
   input  wire logic        REG_WE_I,
   input  wire logic        REG_RE_I,
   input  wire logic [7:0]  REG_ADDR_I,
   input  wire logic [7:0]  REG_WDATA_I,
   output logic      [7:0]  REG_RDATA_O,
   // Frame readout, one pulse per frame drained
   input  wire logic        ACC_FRAME_POP_I,
   input  wire logic        GYR_FRAME_POP_I,
   // Sample path on the sample clock
   input  wire logic        ACC_FRAME_VALID_I,
   input  wire logic        GYR_FRAME_VALID_I,
   input  wire logic [15:0] GYR_Z_I,
   output logic             GYR_Z_VALID_O,
   output logic      [15:0] GYR_Z_O,
   // Interrupt pins
   output logic             ACC_INT1_O,
   output logic             ACC_INT2_O,
   input  wire logic        GYR_INT1_I,
   input  wire logic        GYR_INT2_I,
   output logic             GYR_INT1_O,
   output logic             GYR_INT1_OE_O,
   output logic             GYR_INT2_O,
   output logic             GYR_INT2_OE_O
);

   logic [7:0]   acc_irq_en_q;
   logic [7:0]   acc_pin_map_q;
   logic [7:0]   acc_wm_level_q;
   logic [7:0]   gyro_irq_en_q;
   logic [7:0]   gyro_pin_map_q;
   logic [7:0]   gyro_wm_en_q;
   logic [7:0]   gyro_sync_cfg_q;
   logic [7:0]   gyro_wm_level_q;
   logic [7:0]   qmode_q [2];
   msf_qstat_t   qstat_q [2];
   logic [6:0]   depth [2];
   logic [6:0]   level [2];
   logic [1:0]   cfg_clr;
   logic [1:0]   push;
   logic [1:0]   pop;
   logic [1:0]   wm;
   logic [1:0]   full;
   logic [1:0]   frm_tgl_q;
   logic [1:0]   frm_s1_q;
   logic [1:0]   frm_s2_q;
   logic [1:0]   frm_s3_q;
   logic [1:0]   pin_s1_q;
   logic [1:0]   pin_s2_q;
   msf_smp_cfg_t smp_cfg_q;
   msf_smp_cfg_t cfg_s1_q;
   msf_smp_cfg_t cfg_s2_q;
   logic         seen_q;
   logic         sync_lvl;
   logic         tag;
   logic         sync_on;
   logic         gyro_evt;

   // Configuration registers
   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         acc_irq_en_q    <= `MSF_REG_RESET;
         acc_pin_map_q   <= `MSF_REG_RESET;
         acc_wm_level_q  <= `MSF_REG_RESET;
         gyro_irq_en_q   <= `MSF_REG_RESET;
         gyro_pin_map_q  <= `MSF_REG_RESET;
         gyro_wm_en_q    <= `MSF_REG_RESET;
         gyro_sync_cfg_q <= `MSF_REG_RESET;
         gyro_wm_level_q <= `MSF_REG_RESET;
         qmode_q[0]      <= `MSF_REG_RESET;
         qmode_q[1]      <= `MSF_REG_RESET;
      end
      else if (REG_WE_I)
      begin
         case (REG_ADDR_I)
            `MSF_OFS_QUEUE_MODE:   qmode_q[REG_UNIT_I] <= REG_WDATA_I;
            `MSF_OFS_ACC_IRQ_EN:   if (!REG_UNIT_I) acc_irq_en_q <= REG_WDATA_I;
            `MSF_OFS_ACC_PIN_MAP:  if (!REG_UNIT_I) acc_pin_map_q <= REG_WDATA_I;
            `MSF_OFS_ACC_WM_LEVEL: if (!REG_UNIT_I) acc_wm_level_q <= {2'h0, REG_WDATA_I[5:0]};
            `MSF_OFS_GYR_IRQ_EN:   if (REG_UNIT_I) gyro_irq_en_q <= REG_WDATA_I;
            `MSF_OFS_GYR_PIN_MAP:  if (REG_UNIT_I) gyro_pin_map_q <= REG_WDATA_I;
            `MSF_OFS_GYR_WM_EN:    if (REG_UNIT_I) gyro_wm_en_q <= REG_WDATA_I;
            `MSF_OFS_GYR_SYNC_CFG: if (REG_UNIT_I) gyro_sync_cfg_q <= REG_WDATA_I;
            `MSF_OFS_GYR_WM_LEVEL: if (REG_UNIT_I) gyro_wm_level_q <= REG_WDATA_I;
            default: ;
         endcase
      end
   end

   // Mode or watermark level write resets that unit's queue
   always_comb
   begin
      cfg_clr[0] = REG_WE_I && !REG_UNIT_I &&
                   (REG_ADDR_I == `MSF_OFS_QUEUE_MODE || REG_ADDR_I == `MSF_OFS_ACC_WM_LEVEL);
      cfg_clr[1] = REG_WE_I && REG_UNIT_I &&
                   (REG_ADDR_I == `MSF_OFS_QUEUE_MODE || REG_ADDR_I == `MSF_OFS_GYR_WM_LEVEL);
   end

   assign level[0] = {1'b0, acc_wm_level_q[5:0]};
   assign level[1] = gyro_wm_level_q[6:0];
   assign pop      = {GYR_FRAME_POP_I, ACC_FRAME_POP_I};
   assign push     = frm_s2_q ^ frm_s3_q;

   // Frame arrivals cross from the sample clock as toggles
   always_ff @(posedge SMP_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         frm_tgl_q <= 2'h0;
      else
         frm_tgl_q <= frm_tgl_q ^ {GYR_FRAME_VALID_I, ACC_FRAME_VALID_I};
   end

   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         frm_s1_q <= 2'h0;
         frm_s2_q <= 2'h0;
         frm_s3_q <= 2'h0;
      end
      else
      begin
         frm_s1_q <= frm_tgl_q;
         frm_s2_q <= frm_s1_q;
         frm_s3_q <= frm_s2_q;
      end
   end

   // Per-unit fill counter; depth follows mode only, not axis selection
   for (genvar u = 0; u < 2; u++)
   begin : g_unit
      logic [6:0] after_pop;

      always_comb
      begin
         case (qmode_q[u][7:6])
            `MSF_MODE_FIFO:   depth[u] = (u == 1) ? `MSF_GYR_DEPTH_FIFO : `MSF_ACC_DEPTH_FIFO;
            `MSF_MODE_STREAM: depth[u] = (u == 1) ? `MSF_GYR_DEPTH_STREAM : `MSF_ACC_DEPTH_STREAM;
            default:          depth[u] = `MSF_DEPTH_BYPASS;
         endcase
      end

      assign after_pop = qstat_q[u].cnt - {6'h00, (pop[u] && qstat_q[u].cnt != `MSF_CNT_RESET)};
      assign full[u]   = qstat_q[u].cnt >= depth[u];
      assign wm[u]     = (level[u] != `MSF_CNT_RESET) && (qstat_q[u].cnt >= level[u]);

      always_ff @(posedge MCLK_I or negedge RESET_N_I)
      begin
         if (!RESET_N_I)
            qstat_q[u] <= '0;
         else if (cfg_clr[u])
         begin
            qstat_q[u].cnt <= {6'h00, push[u]};
            qstat_q[u].ovr <= 1'b0;
         end
         else
         begin
            // Every mode sets overrun on an arrival while full and drops it unless a pop frees a slot that cycle; only the depth differs by mode
            qstat_q[u].cnt <= after_pop + {6'h00, (push[u] && after_pop < depth[u])};
            if (push[u] && full[u])
               qstat_q[u].ovr <= 1'b1;
         end
      end
   end

   // Register read-back, one cycle after the read strobe
   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         REG_RDATA_O <= `MSF_REG_RESET;
      else if (REG_RE_I)
      begin
         REG_RDATA_O <= `MSF_REG_RESET;
         case (REG_ADDR_I)
            `MSF_OFS_INT_STATUS:
               if (REG_UNIT_I)
                  REG_RDATA_O[`MSF_BIT_ST_GYR_Q] <= wm[1] | full[1];
               else
               begin
                  REG_RDATA_O[`MSF_BIT_ST_ACC_WM]   <= wm[0];
                  REG_RDATA_O[`MSF_BIT_ST_ACC_FULL] <= full[0];
               end
            `MSF_OFS_QUEUE_STATUS: REG_RDATA_O <= qstat_q[REG_UNIT_I];
            `MSF_OFS_QUEUE_MODE:   REG_RDATA_O <= qmode_q[REG_UNIT_I];
            `MSF_OFS_ACC_IRQ_EN:   if (!REG_UNIT_I) REG_RDATA_O <= acc_irq_en_q;
            `MSF_OFS_ACC_PIN_MAP:  if (!REG_UNIT_I) REG_RDATA_O <= acc_pin_map_q;
            `MSF_OFS_ACC_WM_LEVEL: if (!REG_UNIT_I) REG_RDATA_O <= acc_wm_level_q;
            `MSF_OFS_GYR_IRQ_EN:   if (REG_UNIT_I) REG_RDATA_O <= gyro_irq_en_q;
            `MSF_OFS_GYR_PIN_MAP:  if (REG_UNIT_I) REG_RDATA_O <= gyro_pin_map_q;
            `MSF_OFS_GYR_WM_EN:    if (REG_UNIT_I) REG_RDATA_O <= gyro_wm_en_q;
            `MSF_OFS_GYR_SYNC_CFG: if (REG_UNIT_I) REG_RDATA_O <= gyro_sync_cfg_q;
            `MSF_OFS_GYR_WM_LEVEL: if (REG_UNIT_I) REG_RDATA_O <= gyro_wm_level_q;
            default: ;
         endcase
      end
   end

   // Interrupt pins; the sync pin is released and stays low
   assign sync_on  = gyro_sync_cfg_q[`MSF_BIT_SYNC_EN];
   assign gyro_evt = gyro_irq_en_q[`MSF_BIT_GYR_QUEUE_EN] &&
                     ((wm[1] && gyro_wm_en_q[`MSF_BIT_GYR_WM_IRQ]) || full[1]);

   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         ACC_INT1_O    <= 1'b0;
         ACC_INT2_O    <= 1'b0;
         GYR_INT1_O    <= 1'b0;
         GYR_INT2_O    <= 1'b0;
         GYR_INT1_OE_O <= 1'b0;
         GYR_INT2_OE_O <= 1'b0;
      end
      else
      begin
         ACC_INT1_O <= (wm[0] && acc_irq_en_q[`MSF_BIT_ACC_WM_EN] && acc_pin_map_q[`MSF_BIT_ACC_WM_P1]) ||
                       (full[0] && acc_irq_en_q[`MSF_BIT_ACC_FULL_EN] && acc_pin_map_q[`MSF_BIT_ACC_FULL_P1]);
         ACC_INT2_O <= (wm[0] && acc_irq_en_q[`MSF_BIT_ACC_WM_EN] && acc_pin_map_q[`MSF_BIT_ACC_WM_P2]) ||
                       (full[0] && acc_irq_en_q[`MSF_BIT_ACC_FULL_EN] && acc_pin_map_q[`MSF_BIT_ACC_FULL_P2]);
         GYR_INT1_OE_O <= !(sync_on && !gyro_sync_cfg_q[`MSF_BIT_SYNC_SEL]);
         GYR_INT2_OE_O <= !(sync_on && gyro_sync_cfg_q[`MSF_BIT_SYNC_SEL]);
         GYR_INT1_O <= gyro_evt && gyro_pin_map_q[`MSF_BIT_GYR_Q_P1] &&
                       !(sync_on && !gyro_sync_cfg_q[`MSF_BIT_SYNC_SEL]);
         GYR_INT2_O <= gyro_evt && gyro_pin_map_q[`MSF_BIT_GYR_Q_P2] &&
                       !(sync_on && gyro_sync_cfg_q[`MSF_BIT_SYNC_SEL]);
      end
   end

   // Tagging allowed only outside BYPASS
   always_ff @(posedge MCLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         smp_cfg_q <= '0;
      else
      begin
         smp_cfg_q.en  <= sync_on && (qmode_q[1][7:6] == `MSF_MODE_FIFO ||
                                      qmode_q[1][7:6] == `MSF_MODE_STREAM);
         smp_cfg_q.sel <= gyro_sync_cfg_q[`MSF_BIT_SYNC_SEL];
      end
   end

   // Sample-clock side: synchronisers for config and pins
   always_ff @(posedge SMP_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         cfg_s1_q <= '0;
         cfg_s2_q <= '0;
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
      end
      else
      begin
         cfg_s1_q <= smp_cfg_q;
         cfg_s2_q <= cfg_s1_q;
         pin_s1_q <= {GYR_INT2_I, GYR_INT1_I};
         pin_s2_q <= pin_s1_q;
      end
   end

   assign sync_lvl = cfg_s2_q.en && (cfg_s2_q.sel ? pin_s2_q[1] : pin_s2_q[0]);
   assign tag      = sync_lvl || seen_q;

   // Remembers a high sync level until a word is written with it low
   always_ff @(posedge SMP_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         seen_q <= 1'b0;
      else if (!cfg_s2_q.en)
         seen_q <= 1'b0;
      else if (GYR_FRAME_VALID_I)
         seen_q <= sync_lvl;
      else if (sync_lvl)
         seen_q <= 1'b1;
   end

   always_ff @(posedge SMP_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         GYR_Z_VALID_O <= 1'b0;
         GYR_Z_O       <= 16'h0000;
      end
      else
      begin
         GYR_Z_VALID_O <= GYR_FRAME_VALID_I;
         if (GYR_FRAME_VALID_I)
            GYR_Z_O <= cfg_s2_q.en ? {GYR_Z_I[15:1], tag} : GYR_Z_I;
      end
   end

   // Checks
   property p_clr_empties;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      cfg_clr[0] && !push[0] |=> qstat_q[0].cnt == 7'h00 && !qstat_q[0].ovr;
   endproperty
   a_clr_empties: assert property (p_clr_empties) else $error("Config write did not clear accel queue");

   property p_ovr_set;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      push[1] && full[1] && !cfg_clr[1] |=> qstat_q[1].ovr;
   endproperty
   a_ovr_set: assert property (p_ovr_set) else $error("Overrun not set on arrival while full");

   property p_ovr_sticky;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      qstat_q[0].ovr && !cfg_clr[0] |=> qstat_q[0].ovr;
   endproperty
   a_ovr_sticky: assert property (p_ovr_sticky) else $error("Overrun dropped without config write");

   property p_status_read;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      REG_RE_I && REG_ADDR_I == 8'h0e && REG_UNIT_I |=> REG_RDATA_O == $past(qstat_q[1]);
   endproperty
   a_status_read: assert property (p_status_read) else $error("Queue status read mismatch");

   property p_gyr_cap;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      qmode_q[1][7:6] == 2'h1 |-> qstat_q[1].cnt <= 7'h64;
   endproperty
   a_gyr_cap: assert property (p_gyr_cap) else $error("Gyro fill count above 100");

   property p_sync_pin_released;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      sync_on && gyro_sync_cfg_q[4] |=> !GYR_INT2_OE_O && !GYR_INT2_O;
   endproperty
   a_sync_pin_released: assert property (p_sync_pin_released) else $error("Sync pin still driven");

   property p_acc_route;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      wm[0] && acc_irq_en_q[6] && acc_pin_map_q[1] |=> ACC_INT1_O;
   endproperty
   a_acc_route: assert property (p_acc_route) else $error("Accel watermark not on pin one");

   property p_gyr_gate;
      @(posedge MCLK_I) disable iff (!RESET_N_I)
      !gyro_irq_en_q[6] |=> !GYR_INT1_O && !GYR_INT2_O;
   endproperty
   a_gyr_gate: assert property (p_gyr_gate) else $error("Gyro interrupt without queue enable");

   property p_tag_high;
      @(posedge SMP_CLK_I) disable iff (!RESET_N_I)
      cfg_s2_q.en && sync_lvl && GYR_FRAME_VALID_I |=> GYR_Z_O[0];
   endproperty
   a_tag_high: assert property (p_tag_high) else $error("Word not tagged while sync high");

   property p_tag_low;
      @(posedge SMP_CLK_I) disable iff (!RESET_N_I)
      GYR_FRAME_VALID_I && !sync_lvl && !seen_q && cfg_s2_q.en |=> !GYR_Z_O[0];
   endproperty
   a_tag_low: assert property (p_tag_low) else $error("Tag set after sync low");

   property p_no_tag_off;
      @(posedge SMP_CLK_I) disable iff (!RESET_N_I)
      !cfg_s2_q.en && GYR_FRAME_VALID_I |=> GYR_Z_O == $past(GYR_Z_I);
   endproperty
   a_no_tag_off: assert property (p_no_tag_off) else $error("Word altered with tagging off");

   c_overrun: cover property (@(posedge MCLK_I) disable iff (!RESET_N_I) push[0] && full[0]);
   c_gyr_full: cover property (@(posedge MCLK_I) disable iff (!RESET_N_I) full[1] && GYR_INT1_O);
   c_tagged: cover property (@(posedge SMP_CLK_I) disable iff (!RESET_N_I) GYR_Z_VALID_O && GYR_Z_O[0]);
   c_drain_ovr: cover property (@(posedge MCLK_I) disable iff (!RESET_N_I)
                                qstat_q[0].ovr && qstat_q[0].cnt == 7'h00);

endmodule : msf_status_sync

`default_nettype wire

// *** tb/msf_sensor_model.sv ***
// Sample source beside the queue block: frame strobes and gyro z words
`timescale 1ns/10ps
`default_nettype none

module msf_sensor_model
(
   // Sample clock and reset
   input  wire logic        smp_clk_i,
   input  wire logic        rst_n_i,
   // Frame strobes and z word
   output logic             acc_valid_o,
   output logic             gyr_valid_o,
   output logic      [15:0] gyr_z_o
);
   initial
   begin
      acc_valid_o = 1'b0;
      gyr_valid_o = 1'b0;
      gyr_z_o     = 16'h0000;
   end

   // One frame, then idle cycles so the host can keep up
   task automatic send(input logic unit, input int gap);
      wait (rst_n_i);
      @(posedge smp_clk_i);
      acc_valid_o <= ~unit;
      gyr_valid_o <= unit;
      gyr_z_o     <= 16'($urandom);
      @(posedge smp_clk_i);
      acc_valid_o <= 1'b0;
      gyr_valid_o <= 1'b0;
      // Word no longer valid, so the bus shows junk
      gyr_z_o     <= ~gyr_z_o;
      repeat (gap) @(posedge smp_clk_i);
   endtask : send
endmodule : msf_sensor_model
`default_nettype wire

// *** tb/test_motion_sensor_fifo_status_sync.sv ***
// Self-checking bench of the sample queue status block
`include "msf_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module test_motion_sensor_fifo_status_sync
   import msf_pkg::*;
;
   logic        mclk;
   logic        smp_clk;
   logic        rst_n     = 1'b0;
   logic        reg_unit  = 1'b0;
   logic        reg_we    = 1'b0;
   logic        reg_re    = 1'b0;
   logic [7:0]  reg_addr  = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic [7:0]  reg_rdata;
   logic        acc_pop   = 1'b0;
   logic        gyr_pop   = 1'b0;
   logic        acc_valid;
   logic        gyr_valid;
   logic [15:0] gyr_z;
   logic        z_valid;
   logic [15:0] z_out;
   logic        acc_int1;
   logic        acc_int2;
   logic        gyr_int1_o;
   logic        gyr_int1_oe;
   logic        gyr_int2_o;
   logic        gyr_int2_oe;
   logic [1:0]  sync_drv  = 2'b00;
   wire  logic  pin1      = gyr_int1_oe ? gyr_int1_o : sync_drv[0];
   wire  logic  pin2      = gyr_int2_oe ? gyr_int2_o : sync_drv[1];
   int          n_errors  = 0;
   int          samples_checked = 0;
   int          exp_tag   = 3;
   int          cnt [2]   = '{0, 0};
   int          ovr [2]   = '{0, 0};
   int          mode [2]  = '{0, 0};
   int          lvl [2]   = '{0, 0};
   logic [15:0] q_z [$];
   logic [15:0] w;
   logic [8:0]  regs [10] = '{9'h00e, 9'h017, 9'h01a, 9'h030, 9'h03e, 9'h115, 9'h118, 9'h11e, 9'h134, 9'h13d};

   msf_status_sync u_msf_status_sync (
      .MCLK_I            (mclk),
      .SMP_CLK_I         (smp_clk),
      .RESET_N_I         (rst_n),
      .REG_UNIT_I        (reg_unit),
      .REG_WE_I          (reg_we),
      .REG_RE_I          (reg_re),
      .REG_ADDR_I        (reg_addr),
      .REG_WDATA_I       (reg_wdata),
      .REG_RDATA_O       (reg_rdata),
      .ACC_FRAME_POP_I   (acc_pop),
      .GYR_FRAME_POP_I   (gyr_pop),
      .ACC_FRAME_VALID_I (acc_valid),
      .GYR_FRAME_VALID_I (gyr_valid),
      .GYR_Z_I           (gyr_z),
      .GYR_Z_VALID_O     (z_valid),
      .GYR_Z_O           (z_out),
      .ACC_INT1_O        (acc_int1),
      .ACC_INT2_O        (acc_int2),
      .GYR_INT1_I        (pin1),
      .GYR_INT2_I        (pin2),
      .GYR_INT1_O        (gyr_int1_o),
      .GYR_INT1_OE_O     (gyr_int1_oe),
      .GYR_INT2_O        (gyr_int2_o),
      .GYR_INT2_OE_O     (gyr_int2_oe)
   );

   msf_sensor_model u_msf_sensor_model (
      .smp_clk_i   (smp_clk),
      .rst_n_i     (rst_n),
      .acc_valid_o (acc_valid),
      .gyr_valid_o (gyr_valid),
      .gyr_z_o     (gyr_z)
   );

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   initial
   begin
      smp_clk = 1'b0;
      #37.3;
      forever #80 smp_clk = ~smp_clk;
   end

   function automatic int depth(input int u);
      if (mode[u] == 1)
         return u ? 100 : 32;
      if (mode[u] == 2)
         return u ? 99 : 31;
      return 1;
   endfunction : depth

   task automatic test_done;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : test_done

   task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : check

   task automatic wr(input logic u, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_unit  <= u;
      reg_addr  <= a;
      reg_wdata <= d;
      reg_we    <= 1'b1;
      @(posedge mclk);
      reg_we    <= 1'b0;
      if (a == 8'h3e)
         mode[u] = int'(d[7:6]);
      if (a == (u ? 8'h3d : 8'h30))
         lvl[u] = u ? int'(d[6:0]) : int'(d[5:0]);
      if (a == 8'h3e || a == (u ? 8'h3d : 8'h30))
      begin
         cnt[u] = 0;
         ovr[u] = 0;
      end
   endtask : wr

   task automatic rdc(input string what, input logic u, input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_unit <= u;
      reg_addr <= a;
      reg_re   <= 1'b1;
      @(posedge mclk);
      reg_re   <= 1'b0;
      @(negedge mclk);
      check(what, e, reg_rdata);
   endtask : rdc

   task automatic frames(input logic u, input int n);
      for (int i = 0; i < n; i++)
      begin
         u_msf_sensor_model.send(u, $urandom_range(2));
         if (cnt[u] < depth(u))
            cnt[u]++;
         else
            ovr[u] = 1;
      end
      repeat (4) @(posedge smp_clk);
   endtask : frames

   task automatic pops(input logic u, input int n);
      for (int i = 0; i < n; i++)
      begin
         @(posedge mclk);
         acc_pop <= ~u;
         gyr_pop <= u;
         @(posedge mclk);
         acc_pop <= 1'b0;
         gyr_pop <= 1'b0;
         if (cnt[u] > 0)
            cnt[u]--;
      end
   endtask : pops

   task automatic chk_state(input logic u);
      msf_qstat_t st;
      logic       wm;
      logic       full;
      st.ovr = 1'(ovr[u]);
      st.cnt = 7'(cnt[u]);
      wm     = lvl[u] != 0 && cnt[u] >= lvl[u];
      full   = cnt[u] >= depth(u);
      repeat (4) @(posedge mclk);
      rdc("queue status", u, 8'h0e, st);
      rdc("irq status", u, 8'h0a, u ? {3'h0, wm | full, 4'h0} : {1'b0, wm, full, 5'h0});
      check("pin one", u ? wm | full : wm, u ? gyr_int1_o : acc_int1);
      check("pin two", u ? 1'b0 : full, u ? gyr_int2_o : acc_int2);
   endtask : chk_state

   // Gyro z words against the source, tag bit by phase
   always @(posedge smp_clk)
   begin
      if (z_valid === 1'b1)
      begin
         w = q_z.pop_front();
         if (exp_tag == 2)
            check("z upper", w[15:1], z_out[15:1]);
         else
            check("z word", exp_tag == 3 ? w : {w[15:1], exp_tag[0]}, z_out);
      end
      if (gyr_valid === 1'b1)
         q_z.push_back(gyr_z);
   end

   initial
   begin
      repeat (90000) @(posedge mclk);
      n_errors++;
      test_done;
   end

   initial
   begin
      void'($urandom(32'h211d));
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (4) @(posedge smp_clk);
      wr(0, 8'h0e, 8'hff);
      wr(0, 8'h34, 8'h30);
      foreach (regs[i])
         rdc("reset value", regs[i][8], regs[i][7:0], 8'h00);
      rdc("unmapped", 1'b0, 8'h55, 8'h00);
      wr(0, 8'h17, 8'h60);
      wr(0, 8'h1a, 8'h22);
      wr(1, 8'h15, 8'h40);
      wr(1, 8'h1e, 8'h80);
      wr(1, 8'h18, 8'h04);
      rdc("readback", 1'b0, 8'h1a, 8'h22);
      $display("test registers done");
      for (int u = 0; u < 2; u++)
         for (int m = 1; m < 4; m++)
         begin
            wr(u, 8'h3e, 8'(((m % 3) << 6) | $urandom_range(3)));
            frames(u, 2);
            wr(u, u ? 8'h3d : 8'h30, 8'h04);
            chk_state(u);
            frames(u, 4);
            chk_state(u);
            frames(u, depth(u) - 3);
            chk_state(u);
            pops(u, depth(u) + 2);
            chk_state(u);
            $display("test queue unit %0d mode %0d done", u, m % 3);
         end
      for (int s = 0; s < 2; s++)
      begin
         wr(1, 8'h3e, 8'h00);
         wr(1, 8'h34, s ? 8'h30 : 8'h20);
         repeat (8) @(posedge smp_clk);
         check("pin enables", s ? 2'b01 : 2'b10, {gyr_int2_oe, gyr_int1_oe});
         @(posedge mclk);
         sync_drv <= 2'b11;
         repeat (4) @(posedge smp_clk);
         frames(1, 2);
         wr(1, 8'h3e, 8'h40);
         repeat (4) @(posedge smp_clk);
         exp_tag = 1;
         frames(1, 3);
         @(posedge mclk);
         sync_drv <= 2'b00;
         repeat (4) @(posedge smp_clk);
         exp_tag = 2;
         frames(1, 1);
         exp_tag = 0;
         frames(1, 3);
         exp_tag = 3;
         $display("test sync pin %0d done", s);
      end
      check("z words pending", 16'h0000, 16'(q_z.size()));
      test_done;
   end
endmodule : test_motion_sensor_fifo_status_sync
`default_nettype wire
